// file: ewt_ctrl.sv
// module: access sequencer with idle, row, strobe and precharge phases, plus avalon register slave
//
// Notes on behaviour
// - idle field per area: none, one, two
// - read then write gets idle cycles even within one area
// - idle count from the earlier area's field
// - basic wait codes; 00 ignores wait pin
// - long-wait code adds three to six waits
// - area-type field picks memory kind of 2/3
// - dram area 3: cas length one to three
// - dram honours wait pin from two cycles
// - sdram wait field gives cas latency
// - sdram always ignores the wait pin
// - pseudo-sram: strobe to end two to four
// - pseudo-sram honours wait pin from three
// - precharge gap one or two cycles
// - row to column delay one or two
`timescale 1ns/1ps
module ewt_ctrl (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_acc_req,
  input wire logic [1:0] i_acc_area,
  input wire logic i_acc_write,
  input wire logic i_wait_n,
  output logic o_acc_done,
  output logic o_idle_gap,
  output logic o_row_phase,
  output logic o_col_phase,
  output logic o_precharge
);
  // one-hot sequencer states
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_GAP = 5'b00010,
    S_ROW = 5'b00100,
    S_COL = 5'b01000,
    S_PRE = 5'b10000
  } ewt_state_e;

  ewt_state_e state_r; // sequencer state
  logic [3:0] cnt_r; // cycles left in phase
  logic [1:0] area_r; // area of access in hand
  logic wr_r; // direction of access in hand
  logic [1:0] last_area_r; // area of previous access
  logic last_wr_r; // direction of previous access
  logic prev_valid_r; // a previous access exists
  logic [15:0] wcr_r; // wait_idle_config
  logic [15:0] mcr_r; // memory_timing_config
  logic [15:0] bcr_r; // bus_control_first
  logic wait_sync_n; // synchronised wait pin
  logic take; // request accepted this cycle
  logic need_idle; // area change or read-then-write
  logic stall; // wait pin extends strobe
  logic bus_wr; // register write takes effect

  ewt_tim_if tif ();

  // decoder sees the incoming area while idle, the held one afterwards
  assign tif.area = (state_r == S_IDLE) ? i_acc_area : area_r;
  assign tif.prev_area = last_area_r;
  assign tif.wait_idle_config = wcr_r;
  assign tif.memory_timing_config = mcr_r;
  assign tif.bcr = bcr_r;

  ewt_timing_dec u_dec (
    .tif(tif)
  );

  ewt_sync2 u_wait_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async(i_wait_n),
    .o_sync(wait_sync_n)
  );

  // request taken only once its previous done pulse has been seen
  assign take = (state_r == S_IDLE) && i_acc_req && !o_acc_done;
  // idle only on area change or read followed by write
  assign need_idle = prev_valid_r && ((i_acc_area != last_area_r) || (!last_wr_r && i_acc_write));
  // wait pin counts only when the decoded setting enables it
  assign stall = tif.ext_wait_en && !wait_sync_n;

  // sequencer: idle gap, row delay, strobe phase, precharge
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_r <= S_IDLE;
      cnt_r <= 4'h0;
    end else begin
      unique case (state_r)
        S_IDLE: begin
          if (take) begin
            if (need_idle && tif.idle_cycles != 2'h0) begin
              // gap length from the earlier area
              state_r <= S_GAP;
              cnt_r <= {2'h0, tif.idle_cycles};
            end else if (tif.kind != ewt_pkg::KIND_BASIC) begin
              state_r <= S_ROW;
              cnt_r <= {2'h0, tif.rcd_cycles};
            end else begin
              state_r <= S_COL;
              cnt_r <= tif.col_cycles;
            end
          end
        end
        S_GAP: begin
          if (cnt_r == 4'h1) begin
            // memory kinds open a row first
            if (tif.kind != ewt_pkg::KIND_BASIC) begin
              state_r <= S_ROW;
              cnt_r <= {2'h0, tif.rcd_cycles};
            end else begin
              state_r <= S_COL;
              cnt_r <= tif.col_cycles;
            end
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        S_ROW: begin
          if (cnt_r == 4'h1) begin
            state_r <= S_COL;
            cnt_r <= tif.col_cycles;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        S_COL: begin
          if (cnt_r == 4'h1) begin
            // last cycle is stretched while the wait pin holds
            if (!stall) begin
              if (tif.kind != ewt_pkg::KIND_BASIC) begin
                state_r <= S_PRE;
                cnt_r <= {2'h0, tif.trp_cycles};
              end else begin
                state_r <= S_IDLE;
              end
            end
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        S_PRE: begin
          if (cnt_r == 4'h1) begin
            state_r <= S_IDLE;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
      endcase
    end
  end

  // hold the access in hand
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      area_r <= 2'h0;
      wr_r <= 1'b0;
    end else if (take) begin
      area_r <= i_acc_area;
      wr_r <= i_acc_write;
    end
  end

  // history of the previous access, recorded as its strobe ends
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      last_area_r <= 2'h0;
      last_wr_r <= 1'b0;
      prev_valid_r <= 1'b0;
    end else if (state_r == S_COL && cnt_r == 4'h1 && !stall) begin
      last_area_r <= area_r;
      last_wr_r <= wr_r;
      prev_valid_r <= 1'b1;
    end
  end

  // done pulse one cycle after the strobe phase ends
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_acc_done <= 1'b0;
    end else begin
      o_acc_done <= (state_r == S_COL) && (cnt_r == 4'h1) && !stall;
    end
  end

  // phase outputs registered from the current state, one cycle late
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_idle_gap <= 1'b0;
      o_row_phase <= 1'b0;
      o_col_phase <= 1'b0;
      o_precharge <= 1'b0;
    end else begin
      o_idle_gap <= (state_r == S_GAP);
      o_row_phase <= (state_r == S_ROW);
      o_col_phase <= (state_r == S_COL);
      o_precharge <= (state_r == S_PRE);
    end
  end

  // avalon: one wait cycle, then the request completes
  assign bus_wr = i_avs_write && !o_avs_waitrequest;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_avs_waitrequest <= 1'b1;
    end else if ((i_avs_read || i_avs_write) && o_avs_waitrequest) begin
      o_avs_waitrequest <= 1'b0;
    end else begin
      o_avs_waitrequest <= 1'b1;
    end
  end

  // configuration registers; fields steer the decoder
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wcr_r <= ewt_pkg::RST_WAIT_IDLE;
      mcr_r <= ewt_pkg::RST_MEM_TIMING;
      bcr_r <= ewt_pkg::RST_BUS_CTRL;
    end else if (bus_wr) begin
      // status and unmapped offsets ignore writes
      if (i_avs_address == ewt_pkg::OFS_WAIT_IDLE) wcr_r <= i_avs_writedata[15:0];
      if (i_avs_address == ewt_pkg::OFS_MEM_TIMING) mcr_r <= i_avs_writedata[15:0] & ewt_pkg::MASK_MEM_TIMING;
      if (i_avs_address == ewt_pkg::OFS_BUS_CTRL) bcr_r <= i_avs_writedata[15:0] & ewt_pkg::MASK_BUS_CTRL;
    end
  end

  // read data ready as waitrequest falls; unmapped reads zero
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (i_avs_read && o_avs_waitrequest) begin
      unique case (i_avs_address)
        ewt_pkg::OFS_WAIT_IDLE: o_avs_readdata <= {16'h0000, wcr_r};
        ewt_pkg::OFS_MEM_TIMING: o_avs_readdata <= {16'h0000, mcr_r};
        ewt_pkg::OFS_BUS_CTRL: o_avs_readdata <= {16'h0000, bcr_r};
        ewt_pkg::OFS_STATUS: o_avs_readdata <= {23'h000000, state_r, last_wr_r, last_area_r, prev_valid_r};
        default: o_avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ---- checks ----
  sequence s_take_new;
    take && prev_valid_r;
  endsequence

  sequence s_col_start;
    state_r == S_COL && $past(state_r) != S_COL;
  endsequence

  a_idle_area_chg: assert property (@(posedge i_clk) disable iff (i_rst)
    s_take_new and (i_acc_area != last_area_r && tif.idle_cycles != 2'h0)
      |=> state_r == S_GAP && cnt_r == {2'h0, $past(tif.idle_cycles)})
    else $error("idle gap missing on area change");

  a_idle_rd_wr: assert property (@(posedge i_clk) disable iff (i_rst)
    s_take_new and (!last_wr_r && i_acc_write && tif.idle_cycles != 2'h0) |=> state_r == S_GAP)
    else $error("idle gap missing on read then write");

  a_idle_gap_len: assert property (@(posedge i_clk) disable iff (i_rst)
    (state_r == S_IDLE && take && need_idle && tif.idle_cycles == 2'h2)
      |=> (state_r == S_GAP) [*2] ##1 state_r != S_GAP)
    else $error("idle gap length wrong");

  a_no_idle_same: assert property (@(posedge i_clk) disable iff (i_rst)
    s_take_new and (i_acc_area == last_area_r && i_acc_write == last_wr_r) |=> state_r != S_GAP)
    else $error("idle inserted between like accesses");

  a_basic_nowait: assert property (@(posedge i_clk) disable iff (i_rst)
    s_col_start and (tif.kind == ewt_pkg::KIND_BASIC && wcr_r[2*area_r+:2] == 2'h0)
      |-> state_r == S_COL ##1 state_r != S_COL)
    else $error("zero-wait access not one cycle");

  a_long_wait: assert property (@(posedge i_clk) disable iff (i_rst)
    (tif.kind == ewt_pkg::KIND_BASIC && wcr_r[2*tif.area+:2] == 2'h3)
      |-> tif.col_cycles >= 4'h4 && tif.col_cycles <= 4'h7)
    else $error("long wait out of range");

  a_sdram_nowait: assert property (@(posedge i_clk) disable iff (i_rst)
    (state_r == S_COL && tif.kind == ewt_pkg::KIND_SDRAM && cnt_r == 4'h1) |=> state_r != S_COL)
    else $error("sdram strobe stretched by wait pin");

  a_dram_wait_en: assert property (@(posedge i_clk) disable iff (i_rst)
    (tif.kind == ewt_pkg::KIND_DRAM) |-> tif.ext_wait_en == (wcr_r[7:6] != 2'h0))
    else $error("dram wait enable wrong");

  a_psram_len: assert property (@(posedge i_clk) disable iff (i_rst)
    (tif.kind == ewt_pkg::KIND_PSRAM && wcr_r[7:6] == 2'h0) |-> tif.col_cycles == 4'h2 && !tif.ext_wait_en)
    else $error("pseudo-sram length wrong");

  a_rcd_len: assert property (@(posedge i_clk) disable iff (i_rst)
    (state_r == S_ROW && $past(state_r) != S_ROW && mcr_r[ewt_pkg::ROW_COL_BIT])
      |-> ##1 state_r == S_ROW ##1 state_r == S_COL)
    else $error("row to column delay wrong");

  a_trp_len: assert property (@(posedge i_clk) disable iff (i_rst)
    (state_r == S_PRE && $past(state_r) != S_PRE && !mcr_r[ewt_pkg::PRECHARGE_BIT]) |=> state_r == S_IDLE)
    else $error("precharge gap wrong");
endmodule : ewt_ctrl

// file: ewt_pkg.sv
// package: register map, field layout, reset values and timing codes of the wait-timing block
package ewt_pkg;
  // register byte offsets on the avalon slave
  localparam logic [3:0] OFS_WAIT_IDLE = 4'h0;
  localparam logic [3:0] OFS_MEM_TIMING = 4'h4;
  localparam logic [3:0] OFS_BUS_CTRL = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hC;
  // reset values
  localparam logic [15:0] RST_WAIT_IDLE = 16'hAAFF;
  localparam logic [15:0] RST_MEM_TIMING = 16'h0000;
  localparam logic [15:0] RST_BUS_CTRL = 16'h03C0;
  // writable bits; the rest read as zero
  localparam logic [15:0] MASK_MEM_TIMING = 16'hFEFC;
  localparam logic [15:0] MASK_BUS_CTRL = 16'h03F7;
  // field positions in wait_idle_config
  localparam int WAIT_LSB = 0;
  localparam int IDLE_LSB = 8;
  // field positions in memory_timing_config
  localparam int PRECHARGE_BIT = 15;
  localparam int ROW_COL_BIT = 14;
  // field positions in bus_control_first
  localparam int TYPE_LSB = 0;
  localparam int LW_AREA0_LSB = 4;
  localparam int LW_AREA1_LSB = 6;
  localparam int LW_AREA23_LSB = 8;
  // timing counts in cycles
  localparam logic [3:0] LONG_WAIT_BASE = 4'h3;
  localparam logic [1:0] IDLE_MAX = 2'h2;
  localparam logic [1:0] GAP_SHORT = 2'h1;
  localparam logic [1:0] GAP_LONG = 2'h2;
  // area-type selector codes
  localparam logic [2:0] TYPE_A3_SDRAM = 3'h1;
  localparam logic [2:0] TYPE_A3_DRAM = 3'h2;
  localparam logic [2:0] TYPE_A3_PSRAM = 3'h3;
  localparam logic [2:0] TYPE_A2_SDRAM = 3'h4;
  localparam logic [2:0] TYPE_BOTH_SDRAM = 3'h5;
  // memory kind of an area
  typedef enum logic [1:0] {
    KIND_BASIC = 2'h0,
    KIND_SDRAM = 2'h1,
    KIND_DRAM = 2'h2,
    KIND_PSRAM = 2'h3
  } ewt_kind_e;
  // two-bit field of an area out of a 16-bit register
  function automatic logic [1:0] field2(input logic [15:0] val, input int lsb);
    field2 = val[lsb+:2];
  endfunction : field2
endpackage : ewt_pkg

// file: ewt_tim_if.sv
// interface: configuration and area in, decoded timing out
`timescale 1ns/1ps
interface ewt_tim_if;
  logic [1:0] area; // area of the access in hand
  logic [1:0] prev_area; // area accessed just before
  logic [15:0] wait_idle_config; // wait_idle_config
  logic [15:0] memory_timing_config; // memory_timing_config
  logic [15:0] bcr; // bus_control_first
  ewt_pkg::ewt_kind_e kind; // memory kind of area
  logic [3:0] col_cycles; // strobe-phase length
  logic ext_wait_en; // wait pin honoured
  logic [1:0] idle_cycles; // idle cycles owed by prev area
  logic [1:0] rcd_cycles; // row to column delay
  logic [1:0] trp_cycles; // precharge gap
  modport ctl (output area, prev_area, wait_idle_config, memory_timing_config, bcr,
               input kind, col_cycles, ext_wait_en, idle_cycles, rcd_cycles, trp_cycles);
  modport dec (input area, prev_area, wait_idle_config, memory_timing_config, bcr,
               output kind, col_cycles, ext_wait_en, idle_cycles, rcd_cycles, trp_cycles);
endinterface : ewt_tim_if

// file: ewt_sync2.sv
// module: two-flop synchroniser for the external wait pin
`timescale 1ns/1ps
module ewt_sync2 (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_async,
  output logic o_sync
);
  logic meta_r; // first stage, read only by the second
  // two stages, reset to the pin's idle level (high)
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_r <= 1'b1;
      o_sync <= 1'b1;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end
endmodule : ewt_sync2

// file: ewt_timing_dec.sv
// module: decodes area kind, strobe length, wait enable and gaps from configuration
`timescale 1ns/1ps
module ewt_timing_dec (
  ewt_tim_if.dec tif
);
  logic [2:0] atype; // area-type selector
  logic [1:0] wf; // wait field of area
  logic [1:0] lw; // long-wait code of area
  logic [1:0] iw; // idle field of previous area
  // area kind from selector; reserved codes act as ordinary space
  always_comb begin
    atype = tif.bcr[ewt_pkg::TYPE_LSB+:3];
    tif.kind = ewt_pkg::KIND_BASIC;
    if (tif.area == 2'h3) begin
      if (atype == ewt_pkg::TYPE_A3_SDRAM || atype == ewt_pkg::TYPE_BOTH_SDRAM)
        tif.kind = ewt_pkg::KIND_SDRAM;
      else if (atype == ewt_pkg::TYPE_A3_DRAM)
        tif.kind = ewt_pkg::KIND_DRAM;
      else if (atype == ewt_pkg::TYPE_A3_PSRAM)
        tif.kind = ewt_pkg::KIND_PSRAM;
    end else if (tif.area == 2'h2) begin
      if (atype == ewt_pkg::TYPE_A2_SDRAM || atype == ewt_pkg::TYPE_BOTH_SDRAM)
        tif.kind = ewt_pkg::KIND_SDRAM;
    end
  end
  // strobe length and wait-pin enable per kind
  always_comb begin
    wf = ewt_pkg::field2(tif.wait_idle_config, ewt_pkg::WAIT_LSB + 2 * int'(tif.area));
    if (tif.area == 2'h0) lw = ewt_pkg::field2(tif.bcr, ewt_pkg::LW_AREA0_LSB);
    else if (tif.area == 2'h1) lw = ewt_pkg::field2(tif.bcr, ewt_pkg::LW_AREA1_LSB);
    else lw = ewt_pkg::field2(tif.bcr, ewt_pkg::LW_AREA23_LSB);
    unique case (tif.kind)
      ewt_pkg::KIND_BASIC: begin
        // base cycle plus 0, 1, 2 or long waits
        tif.col_cycles = (wf == 2'h3) ? 4'h1 + ewt_pkg::LONG_WAIT_BASE + {2'h0, lw} : {2'h0, wf} + 4'h1;
        tif.ext_wait_en = (wf != 2'h0);
      end
      ewt_pkg::KIND_DRAM: begin
        // cas length 1..3; reserved code held at 3
        tif.col_cycles = (wf == 2'h3) ? 4'h3 : {2'h0, wf} + 4'h1;
        tif.ext_wait_en = (wf != 2'h0);
      end
      ewt_pkg::KIND_SDRAM: begin
        tif.col_cycles = {2'h0, wf} + 4'h1;
        tif.ext_wait_en = 1'b0;
      end
      ewt_pkg::KIND_PSRAM: begin
        // bus-start to end 2..4; reserved code held at 4
        tif.col_cycles = (wf == 2'h3) ? 4'h4 : {2'h0, wf} + 4'h2;
        tif.ext_wait_en = (wf != 2'h0);
      end
    endcase
  end
  // idle owed by the area accessed first; reserved code held at two
  always_comb begin
    iw = ewt_pkg::field2(tif.wait_idle_config, ewt_pkg::IDLE_LSB + 2 * int'(tif.prev_area));
    tif.idle_cycles = (iw == 2'h3) ? ewt_pkg::IDLE_MAX : iw;
  end
  assign tif.rcd_cycles = tif.memory_timing_config[ewt_pkg::ROW_COL_BIT] ? ewt_pkg::GAP_LONG : ewt_pkg::GAP_SHORT;
  assign tif.trp_cycles = tif.memory_timing_config[ewt_pkg::PRECHARGE_BIT] ? ewt_pkg::GAP_LONG : ewt_pkg::GAP_SHORT;
endmodule : ewt_timing_dec

// file: ewt_mem_model.sv
// partner: external memory wait-pin model that stalls the strobe for a set time
`timescale 1ns/1ps
module ewt_mem_model #(
  parameter int HOLD = 16 // cycles the pin stays low per stall
) (
  input wire logic i_clk,
  input wire logic i_start,
  output logic o_wait_n
);
  logic [4:0] cnt_r = 5'h00; // remaining low cycles
  // count down a stall started by the bench
  always_ff @(posedge i_clk) begin
    if (i_start) begin
      cnt_r <= 5'(HOLD);
    end else if (cnt_r != 5'h00) begin
      cnt_r <= cnt_r - 5'h01;
    end
  end
  // pin rests high (pulled up) outside a stall
  assign o_wait_n = (cnt_r == 5'h00);
endmodule : ewt_mem_model

// file: ewt_ctrl_test.sv
// testbench: registers, access phase lengths and wait-pin handling of the wait-timing block
`timescale 1ns/1ps
module ewt_ctrl_test;
  logic i_clk = 1'b0; // 200 mhz clock
  logic i_rst = 1'b1; // sync reset
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic acc_req = 1'b0;
  logic [1:0] acc_area = 2'h0;
  logic acc_write = 1'b0;
  logic wait_start = 1'b0; // starts a partner stall
  logic wait_n; // wait pin from partner
  logic [31:0] avs_readdata;
  logic avs_waitrequest, acc_done, idle_gap, row_phase, col_phase, precharge;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0; // timeout counter
  // bench copy of configuration and last access
  logic have_prev = 1'b0;
  logic [1:0] prev_area = 2'h0;
  logic prev_wr = 1'b0;
  logic [15:0] wcr_m, bcr_m, mcr_m;
  // stall cases: area type, area, wait code
  logic [6:0] tbl [9] = '{7'h00, 7'h01, 7'h07, 7'h2C, 7'h2D, 7'h1D, 7'h5A, 7'h3C, 7'h3D};

  always #2.5 i_clk = ~i_clk;

  ewt_ctrl i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_avs_address(avs_address), .i_avs_read(avs_read),
    .i_avs_write(avs_write), .i_avs_writedata(avs_writedata), .o_avs_readdata(avs_readdata),
    .o_avs_waitrequest(avs_waitrequest), .i_acc_req(acc_req), .i_acc_area(acc_area),
    .i_acc_write(acc_write), .i_wait_n(wait_n), .o_acc_done(acc_done), .o_idle_gap(idle_gap),
    .o_row_phase(row_phase), .o_col_phase(col_phase), .o_precharge(precharge));
  ewt_mem_model i_mem (.i_clk(i_clk), .i_start(wait_start), .o_wait_n(wait_n));

  // verdict and end of run
  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  // hang guard
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      $display("mismatch at %0t: timeout", $time);
      test_done();
    end
  end

  // compare register data
  task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: register got %0h expected %0h", $time, got, exp);
    end
  endtask : check_reg

  // compare a cycle count
  task automatic check_cnt(input int got, input int exp, input string what);
    n_compared++;
    if (got != exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask : check_cnt

  // one avalon transfer, held until waitrequest is sampled low
  task automatic av(input logic wr, input logic [3:0] a, input logic [15:0] d, output logic [31:0] q);
    @(posedge i_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {16'h0000, d};
    // no local limit: only the hang guard ends a wait
    do begin
      @(posedge i_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : av

  // write wait and bus control registers, track them
  task automatic cfg(input logic [15:0] w, input logic [15:0] b);
    logic [31:0] q;
    av(1'b1, ewt_pkg::OFS_WAIT_IDLE, w, q);
    av(1'b1, ewt_pkg::OFS_BUS_CTRL, b, q);
    wcr_m = w;
    bcr_m = b & 16'h03F7;
  endtask : cfg

  // memory kind: 0 basic, 1 sdram, 2 dram, 3 pseudo-sram
  function automatic int kind_of(input logic [1:0] area);
    logic [2:0] ty;
    ty = bcr_m[2:0];
    if ((area == 2'h3 && (ty == 3'h1 || ty == 3'h5)) || (area == 2'h2 && ty[2] && !ty[1])) return 1;
    if (area == 2'h3 && ty == 3'h2) return 2;
    if (area == 2'h3 && ty == 3'h3) return 3;
    return 0;
  endfunction : kind_of

  // nominal strobe length in cycles
  function automatic int col_len(input logic [1:0] area);
    int c, k;
    c = wcr_m[2*area +: 2];
    k = kind_of(area);
    if (k == 1) return c + 1;
    if (k == 2) return (c == 3) ? 3 : c + 1;
    if (k == 3) return (c == 3) ? 4 : c + 2;
    if (c == 3) return 4 + int'(bcr_m[(area < 2'h2 ? 4 + 2*area : 8) +: 2]);
    return c + 1;
  endfunction : col_len

  // does the wait pin stretch this area
  function automatic int wait_en(input logic [1:0] area);
    int c, k;
    c = wcr_m[2*area +: 2];
    k = kind_of(area);
    return (k == 1) ? 0 : (c != 0);
  endfunction : wait_en

  // one access, phases counted until done, precharge also for four cycles after
  task automatic run_acc(input logic [1:0] area, input logic wr, input bit stall);
    int ni, nr, nc, np, idl, mem, t, dn;
    ni = 0; nr = 0; nc = 0; np = 0; t = 0;
    mem = (kind_of(area) != 0);
    idl = 0;
    if (have_prev && (area != prev_area || (!prev_wr && wr))) begin
      idl = wcr_m[8+2*prev_area +: 2];
      if (idl == 3) idl = 2;
    end
    if (stall) begin
      @(posedge i_clk);
      wait_start <= 1'b1;
      @(posedge i_clk);
      wait_start <= 1'b0;
      repeat (3) @(posedge i_clk);
    end
    @(posedge i_clk);
    acc_req <= 1'b1;
    acc_area <= area;
    acc_write <= wr;
    do begin
      @(posedge i_clk);
      t++;
      ni += int'(idle_gap === 1'b1);
      nr += int'(row_phase === 1'b1);
      nc += int'(col_phase === 1'b1);
      np += int'(precharge === 1'b1);
    end while (acc_done !== 1'b1 && t < 60);
    // done stands one cycle only: capture it here
    dn = int'(acc_done === 1'b1);
    acc_req <= 1'b0;
    repeat (4) begin
      @(posedge i_clk);
      np += int'(precharge === 1'b1);
    end
    check_cnt(dn, 1, "done");
    check_cnt(ni, idl, "idle");
    check_cnt(nr, mem * (1 + mcr_m[14]), "row");
    if (stall) begin
      check_cnt(int'(nc > col_len(area)), wait_en(area), "stretch");
    end else begin
      check_cnt(nc, col_len(area), "strobe");
    end
    check_cnt(np, mem * (1 + mcr_m[15]), "precharge");
    have_prev = 1'b1;
    prev_area = area;
    prev_wr = wr;
  endtask : run_acc

  // reset for six cycles and clear the bench copy
  task automatic do_reset();
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    have_prev = 1'b0;
    wcr_m = 16'hAAFF;
    bcr_m = 16'h03C0;
    mcr_m = 16'h0000;
  endtask : do_reset

  // main sequence
  initial begin : main
    logic [31:0] q;
    logic [6:0] e;
    void'($urandom(80075));
    do_reset();
    av(1'b0, ewt_pkg::OFS_WAIT_IDLE, 16'h0000, q);
    check_reg(q, 32'h0000AAFF);
    av(1'b0, ewt_pkg::OFS_MEM_TIMING, 16'h0000, q);
    check_reg(q, 32'h00000000);
    av(1'b0, ewt_pkg::OFS_BUS_CTRL, 16'h0000, q);
    check_reg(q, 32'h000003C0);
    av(1'b1, ewt_pkg::OFS_BUS_CTRL, 16'hFFFF, q);
    av(1'b0, ewt_pkg::OFS_BUS_CTRL, 16'h0000, q);
    check_reg(q, 32'h000003F7);
    av(1'b1, 4'h1, 16'h1234, q);
    av(1'b0, 4'h1, 16'h0000, q);
    check_reg(q, 32'h00000000);
    av(1'b0, ewt_pkg::OFS_WAIT_IDLE, 16'h0000, q);
    check_reg(q, 32'h0000AAFF);
    // same area and read-then-write corners
    cfg(16'h5500, 16'h0000);
    run_acc(2'h0, 1'b0, 1'b0);
    run_acc(2'h0, 1'b0, 1'b0);
    run_acc(2'h0, 1'b1, 1'b0);
    run_acc(2'h0, 1'b1, 1'b0);
    run_acc(2'h1, 1'b0, 1'b0);
    // idle count follows the earlier area
    cfg(16'h0600, 16'h0000);
    run_acc(2'h0, 1'b0, 1'b0);
    run_acc(2'h1, 1'b0, 1'b0);
    run_acc(2'h0, 1'b0, 1'b0);
    // status: idle state, last access a read of area 0, history valid
    av(1'b0, ewt_pkg::OFS_STATUS, 16'h0000, q);
    check_reg(q, 32'h00000011);
    // wait pin honoured or ignored per kind and code
    for (int i = 0; i < 9; i++) begin
      e = tbl[i];
      cfg({8'h00, {4{e[1:0]}}}, {6'h00, 6'h00, 1'b0, e[6:4]});
      run_acc(e[3:2], 1'b0, 1'b1);
    end
    // random configurations with one-cycle gaps
    for (int i = 0; i < 60; i++) begin
      cfg(16'($urandom), {6'h00, 6'($urandom), 1'b0, 3'($urandom_range(5))});
      run_acc(2'($urandom), 1'($urandom), 1'b0);
    end
    // second reset, timing register written once with two-cycle gaps
    do_reset();
    av(1'b1, ewt_pkg::OFS_MEM_TIMING, 16'hC000, q);
    mcr_m = 16'hC000;
    av(1'b0, ewt_pkg::OFS_MEM_TIMING, 16'h0000, q);
    check_reg(q, 32'h0000C000);
    for (int i = 0; i < 30; i++) begin
      cfg(16'($urandom), {6'h00, 6'($urandom), 1'b0, 3'($urandom_range(5))});
      run_acc({1'b1, 1'($urandom)}, 1'($urandom), 1'b0);
    end
    test_done();
  end
endmodule : ewt_ctrl_test
